//--- verilog/irq_ctrl_pkg.sv
// Notes on behaviour
// RULE_01 - third enable register bits 2..0 enable auxiliary, second B-channel, C/I change
// RULE_02 - usb device request needs its enable, device line enable and global enable
// RULE_03 - usb device enable register reachable only while endpoint select holds 80 hex
// RULE_04 - usb device enables bits 7..0: se0, attach, detach, suspend, change, status, setup, frame
// RULE_05 - endpoint n enable register selected by endpoint select value 0n hex
// RULE_06 - endpoint request needs specific enable, summary flag, line enable, global enable
// RULE_07 - endpoint enables gate matching request flags; bit 4 reads zero
// RULE_08 - buffer control bit 4 enables summary flag; line enable gates all endpoints
// RULE_09 - buffer control registers reached through endpoint select value 0n hex
// RULE_10 - configuration request enable bit 0 enables its interrupt; other bits read zero
// RULE_11 - software writes zero to isdn status initialise after reset, then leaves it
// RULE_12 - software masks isdn sources only through second and third enable registers
// RULE_13 - fourteen sources sit in six groups by enable bit position
// RULE_14 - group level is high bit from high register, low bit from low register
// RULE_15 - only a strictly higher level preempts; higher level served first
// RULE_16 - equal levels served in scan order: lower group first, then left column first
// RULE_17 - flags sampled at sample phase each machine cycle, polled next cycle, long call
// RULE_18 - a blocked or vanished request is not remembered
// RULE_19 - hardware clears request flags of some sources on vectoring only
// RULE_20 - fixed vector per source
// RULE_21 - wakeup from suspend raises non-maskable request to vector 007b
// RULE_22 - in suspend external zero ignores its enable and goes to non-maskable vector
// RULE_23 - global enable cleared blocks all maskable requests
// RULE_24 - endpoint summary flags clear when software reads them
// RULE_25 - reserved and constant zero bits read zero, writes ignored
`default_nettype none
package irq_ctrl_pkg;
  localparam logic [7:0] ADDR_EN_A        = 8'ha8;
  localparam logic [7:0] ADDR_EN_B        = 8'ha9;
  localparam logic [7:0] ADDR_EN_C        = 8'haa;
  localparam logic [7:0] ADDR_PRIO_HIGH   = 8'hac;
  localparam logic [7:0] ADDR_PRIO_LOW    = 8'hb8;
  localparam logic [7:0] ADDR_EP_BUF_CTRL = 8'hc1;
  localparam logic [7:0] ADDR_EP_IRQ_EN   = 8'hc3;
  localparam logic [7:0] ADDR_EP_SELECT   = 8'hd2;
  localparam logic [7:0] ADDR_SUMMARY     = 8'hd6;
  localparam logic [7:0] ADDR_CFG_EN      = 8'hd8;

  localparam logic [7:0] MASK_EN_A      = 8'hbb;
  localparam logic [7:0] MASK_EN_B      = 8'h3f;
  localparam logic [7:0] MASK_EN_C      = 8'h07;
  localparam logic [7:0] MASK_PRIO      = 8'h3f;
  localparam logic [7:0] MASK_EP_BUF    = 8'h9d;
  localparam logic [7:0] MASK_EP_IRQ_EN = 8'hef;
  localparam logic [7:0] MASK_CFG_EN    = 8'h01;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [7:0] SELECT_USB_DEV = 8'h80;

  localparam int GLOBAL_EN_BIT    = 7;
  localparam int USB_DEV_LINE_BIT = 5;
  localparam int EP_LINE_BIT      = 0;
  localparam int EP_SUMMARY_BIT   = 4;
  localparam int CFG_REQ_BIT      = 0;

  localparam int NUM_SOURCES   = 14;
  localparam int NUM_ENDPOINTS = 8;

  localparam logic [3:0] MACHINE_CYCLE_CLOCKS = 4'd12;
  localparam logic [3:0] SAMPLE_PHASE_CLOCK   = 4'd9;

  localparam logic [3:0] SRC_EXT0 = 4'd0;
  localparam logic [3:0] SRC_TMR0 = 4'd1;
  localparam logic [3:0] SRC_TMR1 = 4'd2;
  localparam logic [3:0] SRC_EEP  = 4'd3;
  localparam logic [3:0] SRC_USB  = 4'd4;
  localparam logic [3:0] SRC_EP   = 4'd5;
  localparam logic [3:0] SRC_B1   = 4'd6;
  localparam logic [3:0] SRC_D    = 4'd7;
  localparam logic [3:0] SRC_ST   = 4'd8;
  localparam logic [3:0] SRC_MON  = 4'd9;
  localparam logic [3:0] SRC_TRAN = 4'd10;
  localparam logic [3:0] SRC_CIC  = 4'd11;
  localparam logic [3:0] SRC_B2   = 4'd12;
  localparam logic [3:0] SRC_AUX  = 4'd13;

  localparam logic [0:13][15:0] VECTOR_TABLE = '{16'h0003, 16'h000b, 16'h001b, 16'h0023, 16'h002b,
    16'h0033, 16'h003b, 16'h0043, 16'h004b, 16'h0053, 16'h005b, 16'h0063, 16'h006b, 16'h0083};
  localparam logic [15:0] NMI_VECTOR = 16'h007b;
  localparam logic [0:13][2:0] GROUP_OF = '{3'd0, 3'd1, 3'd3, 3'd4, 3'd5, 3'd0, 3'd1,
    3'd2, 3'd3, 3'd4, 3'd5, 3'd0, 3'd1, 3'd2};
  localparam logic [0:13][3:0] SCAN_ORDER = '{SRC_EXT0, SRC_EP, SRC_CIC, SRC_TMR0, SRC_B1, SRC_B2,
    SRC_D, SRC_AUX, SRC_TMR1, SRC_ST, SRC_EEP, SRC_MON, SRC_USB, SRC_TRAN};
  localparam logic [13:0] HW_CLEAR_DEFAULT = 14'h0007;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfr_req_t;

  typedef struct packed {
    logic [15:0] vector;
    logic [1:0]  level;
    logic        nmi;
  } call_t;
endpackage
`default_nettype wire

//--- verilog/usb_isdn_irq_priority_ctrl.sv
`default_nettype none
module usb_isdn_irq_priority_ctrl
  import irq_ctrl_pkg::*;
#(
  parameter logic [13:0] HW_CLEAR_MASK = HW_CLEAR_DEFAULT
) (
  input  wire  logic            clock,
  input  wire  logic            rst,
  input  wire  sfr_req_t        sfr_req,
  output logic [7:0]            sfr_rdata,
  input  wire  logic            ext_pin_zero,
  input  wire  logic            timer0_flag,
  input  wire  logic            timer1_flag,
  input  wire  logic            eeprom_flag,
  input  wire  logic [7:0]      usb_device_flags,
  input  wire  logic            config_request_flag,
  input  wire  logic [7:0][7:0] ep_request_flags,
  input  wire  logic            hdlc_b1_source,
  input  wire  logic            hdlc_b2_source,
  input  wire  logic            hdlc_d_source,
  input  wire  logic            sync_transfer_source,
  input  wire  logic            monitor_source,
  input  wire  logic            transceiver_source,
  input  wire  logic            ci_change_source,
  input  wire  logic            aux_source,
  input  wire  logic            suspend_mode,
  input  wire  logic            wakeup_event,
  input  wire  logic            irq_return,
  output logic                  long_call,
  output call_t                 call_info,
  output logic                  nmi_request,
  output logic [13:0]           hw_flag_clear,
  output logic [7:0]            ep_summary_flags,
  output logic                  sample_phase
);

  logic [7:0]      irq_enable_a_reg;
  logic [7:0]      irq_enable_b_reg;
  logic [7:0]      irq_enable_c_reg;
  logic [7:0]      priority_high_bits_reg;
  logic [7:0]      priority_low_bits_reg;
  logic [7:0]      config_request_irq_enable_reg;
  logic [7:0]      endpoint_select_reg;
  logic [7:0]      usb_device_irq_enable_reg;
  logic [7:0][7:0] endpoint_buffer_control_reg;
  logic [7:0][7:0] endpoint_irq_enable_reg;
  logic [7:0]      ep_summary_flags_reg;
  logic [7:0]      ep_summary_set;
  logic [3:0]      phase_reg;
  logic            sample_phase_reg;
  logic            poll_phase_reg;
  logic [13:0]     req_gated;
  logic [13:0]     sample_reg;
  logic            nmi_source;
  logic            nmi_sample_reg;
  logic            nmi_request_reg;
  logic [3:0]      in_service_reg;
  logic            nmi_in_service_reg;
  logic [3:0]      ret_clear;
  logic            long_call_reg;
  call_t           call_info_reg;
  logic [13:0]     hw_flag_clear_reg;
  logic [7:0]      sfr_rdata_reg;
  logic [7:0]      rd_value;
  logic            global_en;
  logic            ep_sel_valid;
  logic [2:0]      ep_index;
  logic            usb_dev_selected;
  logic            summary_read;
  logic            win_found;
  logic [3:0]      win_src;
  logic [1:0]      win_level;
  logic            call_allowed;

  function automatic logic [1:0] level_of(input logic [3:0] src, input logic [7:0] hi, input logic [7:0] lo);
    level_of = {hi[GROUP_OF[src]], lo[GROUP_OF[src]]}; // RULE_13 RULE_14
  endfunction

  function automatic logic [1:0] top_level(input logic [3:0] active);
    top_level = active[3] ? 2'd3 : active[2] ? 2'd2 : active[1] ? 2'd1 : 2'd0;
  endfunction

  assign global_en        = irq_enable_a_reg[GLOBAL_EN_BIT];
  assign ep_sel_valid     = (endpoint_select_reg[7:3] == 5'h00); // RULE_05 RULE_09
  assign ep_index         = endpoint_select_reg[2:0];
  assign usb_dev_selected = (endpoint_select_reg == SELECT_USB_DEV); // RULE_03
  assign summary_read     = sfr_req.rd && (sfr_req.addr == ADDR_SUMMARY);

  // mixed-access registers keep only their writable bits, so reserved bits read zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_enable_a_reg              <= REG_RESET;
      irq_enable_b_reg              <= REG_RESET;
      irq_enable_c_reg              <= REG_RESET;
      priority_high_bits_reg        <= REG_RESET;
      priority_low_bits_reg         <= REG_RESET;
      config_request_irq_enable_reg <= REG_RESET;
      endpoint_select_reg           <= REG_RESET;
    end else if (sfr_req.wr) begin
      case (sfr_req.addr)
        ADDR_EN_A:      irq_enable_a_reg <= sfr_req.wdata & MASK_EN_A; // RULE_25
        ADDR_EN_B:      irq_enable_b_reg <= sfr_req.wdata & MASK_EN_B;
        ADDR_EN_C:      irq_enable_c_reg <= sfr_req.wdata & MASK_EN_C; // RULE_01
        ADDR_PRIO_HIGH: priority_high_bits_reg <= sfr_req.wdata & MASK_PRIO; // RULE_14
        ADDR_PRIO_LOW:  priority_low_bits_reg <= sfr_req.wdata & MASK_PRIO;
        ADDR_CFG_EN:    config_request_irq_enable_reg <= sfr_req.wdata & MASK_CFG_EN; // RULE_10
        ADDR_EP_SELECT: endpoint_select_reg <= sfr_req.wdata;
        default: ;
      endcase
    end
  end

  // select values outside 00..07 and 80 reach nothing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      usb_device_irq_enable_reg   <= REG_RESET;
      endpoint_buffer_control_reg <= '0;
      endpoint_irq_enable_reg     <= '0;
    end else if (sfr_req.wr) begin
      if (sfr_req.addr == ADDR_EP_IRQ_EN && usb_dev_selected) begin
        usb_device_irq_enable_reg <= sfr_req.wdata; // RULE_03 RULE_04
      end else if (sfr_req.addr == ADDR_EP_IRQ_EN && ep_sel_valid) begin
        endpoint_irq_enable_reg[ep_index] <= sfr_req.wdata & MASK_EP_IRQ_EN; // RULE_05 RULE_07
      end else if (sfr_req.addr == ADDR_EP_BUF_CTRL && ep_sel_valid) begin
        endpoint_buffer_control_reg[ep_index] <= sfr_req.wdata & MASK_EP_BUF; // RULE_09
      end
    end
  end

  genvar ep;
  generate
    for (ep = 0; ep < NUM_ENDPOINTS; ep++) begin : g_summary
      assign ep_summary_set[ep] = endpoint_buffer_control_reg[ep][EP_SUMMARY_BIT] &&
                                  |(ep_request_flags[ep] & endpoint_irq_enable_reg[ep]); // RULE_07 RULE_08
      // a new request in the read cycle survives the read
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          ep_summary_flags_reg[ep] <= 1'b0;
        end else if (ep_summary_set[ep]) begin
          ep_summary_flags_reg[ep] <= 1'b1;
        end else if (summary_read) begin
          ep_summary_flags_reg[ep] <= 1'b0; // RULE_24
        end
      end
    end
  endgenerate

  always_comb begin
    rd_value = 8'h00;
    case (sfr_req.addr)
      ADDR_EN_A:        rd_value = irq_enable_a_reg;
      ADDR_EN_B:        rd_value = irq_enable_b_reg;
      ADDR_EN_C:        rd_value = irq_enable_c_reg;
      ADDR_PRIO_HIGH:   rd_value = priority_high_bits_reg;
      ADDR_PRIO_LOW:    rd_value = priority_low_bits_reg;
      ADDR_CFG_EN:      rd_value = config_request_irq_enable_reg;
      ADDR_EP_SELECT:   rd_value = endpoint_select_reg;
      ADDR_SUMMARY:     rd_value = ep_summary_flags_reg;
      ADDR_EP_BUF_CTRL: rd_value = ep_sel_valid ? endpoint_buffer_control_reg[ep_index] : 8'h00;
      ADDR_EP_IRQ_EN: begin
        if (usb_dev_selected) begin
          rd_value = usb_device_irq_enable_reg;
        end else if (ep_sel_valid) begin
          rd_value = endpoint_irq_enable_reg[ep_index];
        end
      end
      default:          rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sfr_rdata_reg <= 8'h00;
    end else begin
      sfr_rdata_reg <= sfr_req.rd ? rd_value : 8'h00;
    end
  end

  // machine cycle divider: sample at SAMPLE_PHASE, poll on the first clock of the next cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_reg        <= 4'h0;
      sample_phase_reg <= 1'b0;
      poll_phase_reg   <= 1'b0;
    end else begin
      phase_reg        <= (phase_reg == MACHINE_CYCLE_CLOCKS - 4'h1) ? 4'h0 : phase_reg + 4'h1;
      sample_phase_reg <= (phase_reg == SAMPLE_PHASE_CLOCK - 4'h1); // RULE_17
      poll_phase_reg   <= (phase_reg == MACHINE_CYCLE_CLOCKS - 4'h1);
    end
  end

  always_comb begin
    req_gated           = '0;
    req_gated[SRC_EXT0] = ext_pin_zero && irq_enable_a_reg[0] && !suspend_mode; // RULE_22
    req_gated[SRC_TMR0] = timer0_flag && irq_enable_a_reg[1];
    req_gated[SRC_TMR1] = timer1_flag && irq_enable_a_reg[3];
    req_gated[SRC_EEP]  = eeprom_flag && irq_enable_a_reg[4];
    req_gated[SRC_USB]  = (|(usb_device_flags & usb_device_irq_enable_reg) ||
                           (config_request_flag && config_request_irq_enable_reg[CFG_REQ_BIT])) &&
                          irq_enable_a_reg[USB_DEV_LINE_BIT]; // RULE_02 RULE_10
    req_gated[SRC_EP]   = |ep_summary_flags_reg && irq_enable_b_reg[EP_LINE_BIT]; // RULE_06 RULE_08
    req_gated[SRC_B1]   = hdlc_b1_source && irq_enable_b_reg[1];
    req_gated[SRC_D]    = hdlc_d_source && irq_enable_b_reg[2];
    req_gated[SRC_ST]   = sync_transfer_source && irq_enable_b_reg[3];
    req_gated[SRC_MON]  = monitor_source && irq_enable_b_reg[4];
    req_gated[SRC_TRAN] = transceiver_source && irq_enable_b_reg[5];
    req_gated[SRC_CIC]  = ci_change_source && irq_enable_c_reg[0]; // RULE_01
    req_gated[SRC_B2]   = hdlc_b2_source && irq_enable_c_reg[1];
    req_gated[SRC_AUX]  = aux_source && irq_enable_c_reg[2];
    if (!global_en) begin
      req_gated = '0; // RULE_23
    end
  end

  assign nmi_source = wakeup_event || (suspend_mode && ext_pin_zero); // RULE_21 RULE_22

  // samples are overwritten every machine cycle, so a denied request leaves no trace
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sample_reg      <= '0;
      nmi_sample_reg  <= 1'b0;
      nmi_request_reg <= 1'b0;
    end else begin
      nmi_request_reg <= nmi_source; // RULE_21
      if (sample_phase_reg) begin
        sample_reg     <= req_gated; // RULE_17 RULE_18
        nmi_sample_reg <= nmi_source;
      end
    end
  end

  // strict greater-than keeps the earlier source in scan order on a tie
  always_comb begin
    win_found = 1'b0;
    win_src   = 4'h0;
    win_level = 2'd0;
    for (int k = 0; k < NUM_SOURCES; k++) begin
      if (sample_reg[SCAN_ORDER[k]] &&
          (!win_found || level_of(SCAN_ORDER[k], priority_high_bits_reg, priority_low_bits_reg) > win_level)) begin
        win_found = 1'b1; // RULE_15 RULE_16
        win_src   = SCAN_ORDER[k];
        win_level = level_of(SCAN_ORDER[k], priority_high_bits_reg, priority_low_bits_reg);
      end
    end
  end

  assign call_allowed = !nmi_in_service_reg &&
                        ((in_service_reg == 4'h0) || (win_level > top_level(in_service_reg))); // RULE_15

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      long_call_reg     <= 1'b0;
      call_info_reg     <= '0;
      hw_flag_clear_reg <= '0;
    end else begin
      long_call_reg     <= 1'b0;
      hw_flag_clear_reg <= '0;
      if (poll_phase_reg && nmi_sample_reg && !nmi_in_service_reg) begin
        long_call_reg        <= 1'b1; // RULE_21
        call_info_reg.vector <= NMI_VECTOR;
        call_info_reg.level  <= 2'd3;
        call_info_reg.nmi    <= 1'b1;
      end else if (poll_phase_reg && win_found && call_allowed) begin
        long_call_reg        <= 1'b1; // RULE_17
        call_info_reg.vector <= VECTOR_TABLE[win_src]; // RULE_20
        call_info_reg.level  <= win_level;
        call_info_reg.nmi    <= 1'b0;
        hw_flag_clear_reg    <= (14'h0001 << win_src) & HW_CLEAR_MASK; // RULE_19
      end
    end
  end

  // a return ends the non-maskable routine first, otherwise the highest active level
  assign ret_clear = (irq_return && !nmi_in_service_reg) ? (4'h1 << top_level(in_service_reg)) : 4'h0;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      in_service_reg     <= 4'h0;
      nmi_in_service_reg <= 1'b0;
    end else begin
      in_service_reg <= (in_service_reg & ~ret_clear) |
                        ((long_call_reg && !call_info_reg.nmi) ? (4'h1 << call_info_reg.level) : 4'h0); // RULE_15
      nmi_in_service_reg <= (nmi_in_service_reg && !irq_return) || (long_call_reg && call_info_reg.nmi);
    end
  end

  assign sfr_rdata        = sfr_rdata_reg;
  assign long_call        = long_call_reg;
  assign call_info        = call_info_reg;
  assign nmi_request      = nmi_request_reg;
  assign hw_flag_clear    = hw_flag_clear_reg;
  assign ep_summary_flags = ep_summary_flags_reg;
  assign sample_phase     = sample_phase_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_en_c_write: assert property ( // RULE_01
    sfr_req.wr && sfr_req.addr == ADDR_EN_C |=> irq_enable_c_reg == ($past(sfr_req.wdata) & 8'h07))
    else $error("third enable register write wrong");
  chk_usb_dev_gate: assert property ( // RULE_02
    req_gated[SRC_USB] |-> global_en && irq_enable_a_reg[USB_DEV_LINE_BIT])
    else $error("usb device request without enables");
  chk_usb_device_irq_enable_select: assert property ( // RULE_03
    sfr_req.wr && sfr_req.addr == ADDR_EP_IRQ_EN && endpoint_select_reg != 8'h80
    |=> $stable(usb_device_irq_enable_reg))
    else $error("usb device enable written without select");
  chk_ep_gate: assert property ( // RULE_06
    req_gated[SRC_EP] |-> global_en && irq_enable_b_reg[0] && ep_summary_flags_reg != 8'h00)
    else $error("endpoint request without enables");
  chk_ep_bit_four: assert property ( // RULE_07
    sfr_req.wr && sfr_req.addr == ADDR_EP_IRQ_EN && endpoint_select_reg == 8'h03
    |=> endpoint_irq_enable_reg[3] == ($past(sfr_req.wdata) & 8'hef))
    else $error("endpoint enable write wrong");
  chk_summary_clear: assert property ( // RULE_24
    summary_read && ep_summary_set == 8'h00 |=> ep_summary_flags_reg == 8'h00)
    else $error("summary flags not cleared by read");
  chk_summary_cause: assert property ( // RULE_08
    $rose(ep_summary_flags_reg[3]) |-> $past(endpoint_buffer_control_reg[3][4]))
    else $error("summary flag set while disabled");
  chk_call_timing: assert property ( // RULE_17
    long_call_reg |-> $past(poll_phase_reg) && $past(sample_phase_reg, 4))
    else $error("call outside poll slot");
  chk_sample_spacing: assert property ( // RULE_17
    sample_phase_reg |=> !sample_phase_reg [*8])
    else $error("sample phase spacing wrong");
  chk_preempt_level: assert property ( // RULE_15
    long_call_reg && !call_info_reg.nmi && $past(in_service_reg) != 4'h0
    |-> call_info_reg.level > top_level($past(in_service_reg)))
    else $error("preemption by equal or lower level");
  chk_nmi_vector: assert property ( // RULE_21
    long_call_reg && call_info_reg.nmi |-> call_info_reg.vector == 16'h007b)
    else $error("non-maskable call to wrong vector");
  chk_ext0_suspend: assert property ( // RULE_22
    suspend_mode && ext_pin_zero |-> !req_gated[SRC_EXT0] ##1 nmi_request_reg)
    else $error("external zero not routed to non-maskable");
  chk_global_block: assert property ( // RULE_23
    !global_en |-> req_gated == 14'h0000)
    else $error("request passed with global enable clear");

  cov_nmi_call: cover property (long_call_reg && call_info_reg.nmi);
  cov_preempt: cover property (long_call_reg && in_service_reg != 4'h0);
  cov_aux_call: cover property (long_call_reg && call_info_reg.vector == 16'h0083);
  cov_summary_read: cover property (summary_read && ep_summary_flags_reg != 8'h00);

endmodule
`default_nettype wire

//--- tb/core_model.sv
`default_nettype none
module core_model #(
  parameter int RETURN_DELAY = 20
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic long_call,
  output var  logic irq_return
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // one return per call, but a call during the count restarts it and drops the earlier return; a long routine body lets pending requests pile up
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      irq_return <= 1'b0;
    end else begin
      irq_return <= (cnt == 1);
      if (long_call) cnt <= RETURN_DELAY;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

//--- tb/usb_isdn_irq_priority_ctrl_bench.sv
`default_nettype none
module usb_isdn_irq_priority_ctrl_bench import irq_ctrl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic            clock, rst, ext_pin_zero, timer0_flag, timer1_flag, suspend_mode, wakeup_event;
  logic            irq_return, long_call, nmi_request, sample_phase;
  logic [9:0]      src;
  logic [7:0]      usb_device_flags, sfr_rdata, ep_summary_flags;
  logic [7:0][7:0] ep_request_flags;
  logic [13:0]     hw_flag_clear, hw_seen;
  sfr_req_t        sfr_req;
  call_t           call_info;
  int              error_cnt, comparisons;

  usb_isdn_irq_priority_ctrl DUT (.clock, .rst, .sfr_req, .sfr_rdata, .ext_pin_zero, .timer0_flag,
    .timer1_flag, .eeprom_flag(src[0]), .usb_device_flags, .config_request_flag(src[9]), .ep_request_flags,
    .hdlc_b1_source(src[1]), .hdlc_d_source(src[2]), .sync_transfer_source(src[3]), .monitor_source(src[4]),
    .transceiver_source(src[5]), .ci_change_source(src[6]), .hdlc_b2_source(src[7]), .aux_source(src[8]),
    .suspend_mode, .wakeup_event, .irq_return, .long_call, .call_info, .nmi_request, .hw_flag_clear,
    .ep_summary_flags, .sample_phase);
  core_model #(.RETURN_DELAY(40)) partner (.clock, .rst, .long_call, .irq_return);

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    sfr_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    sfr_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    sfr_req.rd <= 1'b0;
    #1 check(sfr_rdata, exp);
  endtask

  // step off the edge first: a call that ends at this edge must not count again
  task automatic wait_call(input call_t exp);
    #1;
    for (int i = 0; i < 80 && long_call !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    hw_seen = hw_flag_clear;
    check(long_call, 1'b1);
    check(call_info, exp);
    @(posedge clock);
  endtask

  task automatic quiet();
    repeat (30) begin
      @(posedge clock);
      #1 check(long_call, 1'b0);
    end
    @(posedge clock);
  endtask

  task automatic settle();
    repeat (60) @(posedge clock);
  endtask

  task automatic phase_test();
    int n = 0;
    #1;
    while (sample_phase !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(sample_phase, 1'b1);
    repeat (MACHINE_CYCLE_CLOCKS - 4'h1) begin
      @(posedge clock);
      #1 check(sample_phase, 1'b0);
    end
    @(posedge clock);
    #1 check(sample_phase, 1'b1);
    @(posedge clock);
  endtask

  task automatic regs_test();
    logic [7:0] a [6] = '{8'ha8, 8'ha9, 8'haa, 8'hac, 8'hb8, 8'hd8};
    logic [7:0] m [6] = '{8'hbb, 8'h3f, 8'h07, 8'h3f, 8'h3f, 8'h01};
    for (int i = 0; i < 6; i++) begin
      rd(a[i], 8'h00);
      wr(a[i], 8'hff);
      rd(a[i], m[i]);
      wr(a[i], 8'h00);
    end
    rd(8'h00, 8'h00);
    wr(8'hd2, 8'h03);
    wr(8'hc1, 8'hff);
    rd(8'hc1, 8'h9d);
    wr(8'hc3, 8'hff);
    rd(8'hc3, 8'hef);
    wr(8'hd2, 8'h80);
    rd(8'hc3, 8'h00);
    wr(8'hc3, 8'hff);
    rd(8'hc3, 8'hff);
    wr(8'hd2, 8'h09);
    rd(8'hc3, 8'h00);
  endtask

  task automatic irq_test();
    wr(8'ha8, 8'h02);
    timer0_flag <= 1'b1;
    quiet();
    wr(8'ha8, 8'h82);
    wait_call('{16'h000b, 2'd0, 1'b0});
    check(hw_seen, 14'h0002);
    timer0_flag <= 1'b0;
    settle();
    wr(8'ha8, 8'h8b);
    ext_pin_zero <= 1'b1;
    timer1_flag <= 1'b1;
    wait_call('{16'h0003, 2'd0, 1'b0});
    ext_pin_zero <= 1'b0;
    wait_call('{16'h001b, 2'd0, 1'b0});
    timer1_flag <= 1'b0;
    settle();
    wr(8'hac, 8'h08);
    ext_pin_zero <= 1'b1;
    timer1_flag <= 1'b1;
    wait_call('{16'h001b, 2'd2, 1'b0});
    quiet();
    ext_pin_zero <= 1'b0;
    timer1_flag <= 1'b0;
    settle();
    quiet();
    wr(8'hac, 8'h00);
  endtask

  task automatic nmi_test();
    wr(8'ha8, 8'h81);
    wakeup_event <= 1'b1;
    wait_call('{16'h007b, 2'd3, 1'b1});
    check(nmi_request, 1'b1);
    wakeup_event <= 1'b0;
    settle();
    check(nmi_request, 1'b0);
    suspend_mode <= 1'b1;
    ext_pin_zero <= 1'b1;
    wait_call('{16'h007b, 2'd3, 1'b1});
    check(nmi_request, 1'b1);
    suspend_mode <= 1'b0;
    ext_pin_zero <= 1'b0;
    settle();
  endtask

  task automatic usb_test();
    wr(8'hd2, 8'h80);
    wr(8'hc3, 8'h01);
    usb_device_flags <= 8'h01;
    quiet();
    wr(8'ha8, 8'ha0);
    wait_call('{16'h002b, 2'd0, 1'b0});
    usb_device_flags <= 8'h00;
    settle();
    wr(8'hd2, 8'h03);
    wr(8'hc1, 8'h10);
    wr(8'hc3, 8'h01);
    wr(8'ha9, 8'h01);
    wr(8'ha8, 8'h80);
    ep_request_flags[3] <= 8'h01;
    wait_call('{16'h0033, 2'd0, 1'b0});
    check(hw_seen, 14'h0000);
    check(ep_summary_flags, 8'h08);
    ep_request_flags[3] <= 8'h00;
    rd(8'hd6, 8'h08);
    check(ep_summary_flags, 8'h00);
    rd(8'hd6, 8'h00);
    settle();
  endtask

  task automatic scan_test();
    logic [15:0] v [10] = '{16'h0023, 16'h003b, 16'h0043, 16'h004b, 16'h0053, 16'h005b, 16'h0063,
      16'h006b, 16'h0083, 16'h002b};
    wr(8'ha8, 8'hb0);
    wr(8'ha9, 8'h3e);
    wr(8'haa, 8'h07);
    wr(8'hd8, 8'h01);
    for (int i = 0; i < 10; i++) begin
      src[i] <= 1'b1;
      wait_call('{v[i], 2'd0, 1'b0});
      src[i] <= 1'b0;
      settle();
    end
  endtask

  task automatic complete_run();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    {timer0_flag, timer1_flag, suspend_mode, wakeup_event, ext_pin_zero, src} = '0;
    {usb_device_flags, ep_request_flags, sfr_req} = '0;
    rst = 1'b1;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    regs_test();
    phase_test();
    irq_test();
    nmi_test();
    usb_test();
    scan_test();
    complete_run();
  end

  initial begin
    #(20000 * 50);
    error_cnt++;
    complete_run();
  end
endmodule
`default_nettype wire
